// ===== logic/uart_rx_partial_wake.sv
/*
 * Receiver of the first asynchronous channel with partial-wake reception.
 * Assumes a 125 MHz clock; configuration bits are driven by processor logic
 * on the same clock; the receive pin is asynchronous.
 */
`timescale 1ns/100ps
module uart_rx_partial_wake
    import uart_wake_pkg::*;
#(
    parameter int FIFO_W = DATA_BITS + 2,
    parameter int DEPTH = FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial pin
    input wire logic serial_receive_pin_in,
    // Configuration
    input wire logic standby_wake_enable_in,
    input wire logic cpu_stop_in,
    input wire logic channel_start_bit_in,
    input wire logic channel_stop_bit_in,
    input wire logic error_irq_enable_in,
    input wire logic partial_wake_error_stop_in,
    input wire logic parity_enable_in,
    input wire logic parity_odd_in,
    input wire logic [15:0] prescaler_select_in,
    input wire logic [15:0] channel_data_in,
    input wire logic [15:0] wake_prescaler_in,
    input wire logic [15:0] wake_channel_data_in,
    // Flag clear strobes
    input wire logic clear_errors_in,
    // Received data
    output logic [DATA_BITS-1:0] rx_data_out,
    output logic rx_valid_out,
    input wire logic rx_ready_in,
    // Status
    output logic channel_enabled_status_out,
    output logic partial_wake_mode_out,
    output logic parity_error_flag_out,
    output logic framing_error_flag_out,
    output logic overrun_error_flag_out,
    output logic receive_error_irq_out,
    output logic transfer_end_irq_out
);

    // ------------------------------------------------------------
    // Pin synchroniser and baud tick
    // ------------------------------------------------------------
    logic sync1_ff, sync2_ff, pin_d_ff;
    // Reset to the idle level so no false edge follows reset
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            sync1_ff <= 1'b1;
            sync2_ff <= 1'b1;
            pin_d_ff <= 1'b1;
        end
        else
        begin
            sync1_ff <= serial_receive_pin_in;
            sync2_ff <= sync1_ff;
            pin_d_ff <= sync2_ff;
        end
    end
    wire fall = pin_d_ff && !sync2_ff;

    logic [15:0] pre_ff, nxt_pre;
    logic [6:0] div_ff, nxt_div;
    logic tick;
    wire waking = standby_wake_enable_in;
    wire [15:0] pre_sel = waking ? wake_prescaler_in : prescaler_select_in;
    wire [6:0] div_sel = waking ? wake_channel_data_in[DIV_MSB:DIV_LSB]
                                : channel_data_in[DIV_MSB:DIV_LSB];

    // ------------------------------------------------------------
    // Power state and receiver
    // ------------------------------------------------------------
    power_state_e pw_ff, nxt_pw;
    rx_state_e st_ff, nxt_st;
    logic en_ff, nxt_en;
    logic [3:0] bit_ff, nxt_bit;
    logic [DATA_BITS-1:0] sh_ff, nxt_sh;
    logic par_ff, nxt_par;
    logic wake_mode_ff, nxt_wake_mode;
    err_flags_s flg_ff, nxt_flg;
    logic eirq_ff, nxt_eirq, tirq_ff, nxt_tirq;
    rx_word_s word;
    logic push, fifo_ready, fifo_valid;
    logic [FIFO_W-1:0] fifo_q;
    logic pe, fe, ov, err;

    always_comb
    begin
        nxt_pre = pre_ff;
        nxt_div = div_ff;
        tick = 1'b0;
        if (st_ff == RX_IDLE)
        begin
            // Preload half a bit so every sample lands mid-bit
            nxt_pre = '0;
            nxt_div = {1'b0, div_sel[6:1]};
        end
        else if (pre_ff >= pre_sel)
        begin
            nxt_pre = '0;
            if (div_ff >= div_sel)
            begin
                nxt_div = '0;
                tick = 1'b1;
            end
            else
                nxt_div = div_ff + 7'h01;
        end
        else
            nxt_pre = pre_ff + 16'h0001;
    end

    always_comb
    begin
        nxt_pw = pw_ff;
        nxt_st = st_ff;
        nxt_en = en_ff;
        nxt_bit = bit_ff;
        nxt_sh = sh_ff;
        nxt_par = par_ff;
        nxt_flg = flg_ff;
        nxt_eirq = 1'b0;
        nxt_tirq = 1'b0;
        push = 1'b0;
        pe = 1'b0;
        fe = 1'b0;
        ov = 1'b0;
        word = '0;
        if (channel_start_bit_in)
            nxt_en = 1'b1;
        if (channel_stop_bit_in)
            nxt_en = 1'b0;
        unique case (pw_ff)
            PW_RUN: if (cpu_stop_in && standby_wake_enable_in) nxt_pw = PW_STOP;
            PW_STOP:
            begin
                if (!cpu_stop_in || !standby_wake_enable_in)
                    nxt_pw = PW_RUN;
                else if (fall && en_ff)
                    nxt_pw = PW_WAKE;
            end
            PW_WAKE: if (!standby_wake_enable_in) nxt_pw = PW_RUN;
            default: nxt_pw = PW_RUN;
        endcase
        nxt_wake_mode = (nxt_pw == PW_WAKE);
        unique case (st_ff)
            RX_IDLE:
            // Frames starting outside stop are taken too; only stop-started ones are sure
            if (fall && en_ff)
                nxt_st = RX_START;
            RX_START:
            if (tick)
            begin
                // Pulse too short: stay woken but start nothing
                nxt_st = sync2_ff ? RX_IDLE : RX_DATA;
                nxt_bit = '0;
                nxt_par = parity_odd_in;
            end
            RX_DATA:
            if (tick)
            begin
                nxt_sh = {sync2_ff, sh_ff[DATA_BITS-1:1]};
                nxt_par = par_ff ^ sync2_ff;
                nxt_bit = bit_ff + 4'h1;
                if (bit_ff == 4'(DATA_BITS - 1))
                    nxt_st = parity_enable_in ? RX_PARITY : RX_STOP;
            end
            RX_PARITY:
            if (tick)
            begin
                nxt_par = par_ff ^ sync2_ff;
                nxt_st = RX_STOP;
            end
            RX_STOP:
            if (tick)
            begin
                nxt_st = RX_IDLE;
                pe = parity_enable_in && par_ff;
                fe = !sync2_ff;
                ov = !fifo_ready;
                word.data = sh_ff;
                word.parity_err = pe;
                word.framing_err = fe;
                push = 1'b1;
                nxt_tirq = 1'b1;
            end
            default: nxt_st = RX_IDLE;
        endcase
        err = pe || fe || ov;
        if (!(standby_wake_enable_in && partial_wake_error_stop_in))
        begin
            nxt_flg.parity_err = flg_ff.parity_err || pe;
            nxt_flg.framing_err = flg_ff.framing_err || fe;
            nxt_flg.overrun_err = flg_ff.overrun_err || ov;
            nxt_eirq = err && error_irq_enable_in;
        end
        if (clear_errors_in)
        begin
            // A new error in the same cycle wins over the clear
            nxt_flg.framing_err = fe && !(standby_wake_enable_in && partial_wake_error_stop_in);
            nxt_flg.overrun_err = ov && !(standby_wake_enable_in && partial_wake_error_stop_in);
            nxt_flg.parity_err = pe && !(standby_wake_enable_in && partial_wake_error_stop_in);
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            pre_ff <= PRESCALE_RESET;
            div_ff <= DIV_RESET;
            pw_ff <= PW_RUN;
            st_ff <= RX_IDLE;
            en_ff <= 1'b0;
            bit_ff <= '0;
            sh_ff <= '0;
            par_ff <= 1'b0;
            wake_mode_ff <= 1'b0;
            flg_ff <= '0;
            eirq_ff <= 1'b0;
            tirq_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= nxt_pre;
            div_ff <= nxt_div;
            pw_ff <= nxt_pw;
            st_ff <= nxt_st;
            en_ff <= nxt_en;
            bit_ff <= nxt_bit;
            sh_ff <= nxt_sh;
            par_ff <= nxt_par;
            wake_mode_ff <= nxt_wake_mode;
            flg_ff <= nxt_flg;
            eirq_ff <= nxt_eirq;
            tirq_ff <= nxt_tirq;
        end
    end

    // ------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------
    uart_wake_fifo #(.WIDTH(FIFO_W), .DEPTH(DEPTH)) u_fifo (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .in_valid_in(push && fifo_ready),
        .in_ready_out(fifo_ready),
        .in_data_in(FIFO_W'(word)),
        .out_valid_out(fifo_valid),
        .out_ready_in(rx_ready_in && fifo_valid),
        .out_data_out(fifo_q)
    );

    assign rx_data_out = fifo_q[FIFO_W-1 -: DATA_BITS];
    assign rx_valid_out = fifo_valid;
    assign channel_enabled_status_out = en_ff;
    assign partial_wake_mode_out = wake_mode_ff;
    assign parity_error_flag_out = flg_ff.parity_err;
    assign framing_error_flag_out = flg_ff.framing_err;
    assign overrun_error_flag_out = flg_ff.overrun_err;
    assign receive_error_irq_out = eirq_ff;
    assign transfer_end_irq_out = tirq_ff;
endmodule // uart_rx_partial_wake

// ===== logic/uart_wake_fifo.sv
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes writer and reader share the single clock.
 */
`timescale 1ns/100ps
module uart_wake_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // Drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
    logic [AW:0] cnt_ff, nxt_cnt;
    logic [WIDTH-1:0] q_ff, nxt_q;
    logic valid_ff, nxt_valid, ready_ff, nxt_ready;
    logic push, pop;

    always_comb
    begin
        push = in_valid_in && ready_ff;
        pop = out_ready_in && valid_ff;
        nxt_wr = push ? wr_ff + 1'b1 : wr_ff;
        nxt_rd = pop ? rd_ff + 1'b1 : rd_ff;
        nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        nxt_valid = (nxt_cnt != '0);
        nxt_ready = (nxt_cnt != (AW+1)'(DEPTH));
        // Head slot written this cycle: take the word past the array
        nxt_q = (push && (wr_ff == nxt_rd)) ? in_data_in : mem_ff[nxt_rd];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
            q_ff <= '0;
            valid_ff <= 1'b0;
            ready_ff <= 1'b1;
        end
        else
        begin
            wr_ff <= nxt_wr;
            rd_ff <= nxt_rd;
            cnt_ff <= nxt_cnt;
            q_ff <= nxt_q;
            valid_ff <= nxt_valid;
            ready_ff <= nxt_ready;
        end
        if (push)
            mem_ff[wr_ff] <= in_data_in;
    end

    assign in_ready_out = ready_ff;
    assign out_valid_out = valid_ff;
    assign out_data_out = q_ff;
endmodule // uart_wake_fifo

// ===== logic/uart_wake_pkg.sv
/*
 * Package for the partial-wake serial receiver: constants, states and carriers.
 * Assumes one 125 MHz clock and a synchronous active-high reset.
 */
// Behaviour
// - Once the processor is in stop with wake enable set and the channel enabled, a start bit on the receive pin begins a partial-wake frame.
// - Only the first asynchronous channel offers partial-wake reception.
// - With wake enable set, only frames starting in stop are guaranteed; others may flag errors.
// - With wake enable and error stop both set, parity, framing and overrun neither set flags nor raise the error irq.
// - A valid edge moves stop to partial wake; a too-short pulse starts no transfer.
// - With error irq enable low, errors raise no error irq, but transfer end is still raised.
// - With error irq enable high and error stop low, an error raises the error irq.
package uart_wake_pkg;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam int CLK_HZ = 125000000;
    localparam int MAX_WAKE_BPS = 4800;
    localparam logic [6:0] DIV_RESET = 7'h00;
    localparam logic [15:0] PRESCALE_RESET = 16'h0000;
    localparam int DIV_LSB = 9;
    localparam int DIV_MSB = 15;
    localparam int DATA_BITS = 8;
    localparam int FIFO_DEPTH = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_e;
    typedef enum logic [1:0] {PW_RUN, PW_STOP, PW_WAKE} power_state_e;

    typedef struct packed {
        logic parity_err;
        logic framing_err;
        logic overrun_err;
    } err_flags_s;

    typedef struct packed {
        logic [DATA_BITS-1:0] data;
        logic parity_err;
        logic framing_err;
    } rx_word_s;

endpackage

// ===== verification/uart_rx_partial_wake_asserts.sv
/*
 * Checker for the partial-wake receiver, bound to its top module.
 * Assumes configuration inputs change only between frames.
 */
`timescale 1ns/100ps
module uart_rx_partial_wake_asserts
    import uart_wake_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Configuration
    input wire logic standby_wake_enable_in,
    input wire logic cpu_stop_in,
    input wire logic error_irq_enable_in,
    input wire logic partial_wake_error_stop_in,
    input wire logic clear_errors_in,
    input wire logic rx_ready_in,
    // Observed outputs
    input wire logic [DATA_BITS-1:0] rx_data_out,
    input wire logic rx_valid_out,
    input wire logic partial_wake_mode_out,
    input wire logic parity_error_flag_out,
    input wire logic framing_error_flag_out,
    input wire logic overrun_error_flag_out,
    input wire logic receive_error_irq_out,
    input wire logic transfer_end_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);
    wire logic masked = standby_wake_enable_in && partial_wake_error_stop_in;
    wire logic any_flag = parity_error_flag_out || framing_error_flag_out
        || overrun_error_flag_out;

    a_mask_no_irq: assert property (masked |-> !receive_error_irq_out)
        else $error("error irq raised while masked");
    a_mask_no_flag: assert property ($rose(any_flag) |-> !$past(masked))
        else $error("error flag set while masked");
    a_eoc_no_irq: assert property (!error_irq_enable_in |-> !receive_error_irq_out)
        else $error("error irq raised while disabled");
    a_err_with_end: assert property (receive_error_irq_out |-> transfer_end_irq_out)
        else $error("error irq without transfer end");
    a_end_one_cycle: assert property (transfer_end_irq_out |=> !transfer_end_irq_out)
        else $error("transfer end longer than one cycle");
    a_wake_entry: assert property ($rose(partial_wake_mode_out)
        |-> $past(cpu_stop_in) && $past(standby_wake_enable_in))
        else $error("partial wake entered outside stop");
    a_wake_release: assert property ($fell(standby_wake_enable_in)
        |-> ##[1:3] !partial_wake_mode_out)
        else $error("partial wake not released");
    a_flag_sticky: assert property (framing_error_flag_out && !clear_errors_in
        |=> framing_error_flag_out)
        else $error("framing flag dropped without clear");
    a_clear_flags: assert property (clear_errors_in
        |=> !any_flag || transfer_end_irq_out)
        else $error("error flags not cleared");
    a_fifo_hold: assert property (rx_valid_out && !rx_ready_in
        |=> rx_valid_out && $stable(rx_data_out))
        else $error("received word changed while stalled");
endmodule // uart_rx_partial_wake_asserts

bind uart_rx_partial_wake uart_rx_partial_wake_asserts chk_u (.clk_in, .rst_in,
    .standby_wake_enable_in, .cpu_stop_in, .error_irq_enable_in,
    .partial_wake_error_stop_in, .clear_errors_in, .rx_ready_in, .rx_data_out,
    .rx_valid_out, .partial_wake_mode_out, .parity_error_flag_out,
    .framing_error_flag_out, .overrun_error_flag_out, .receive_error_irq_out,
    .transfer_end_irq_out);

// ===== verification/uart_rx_partial_wake_tb.sv
/*
 * Self-checking bench for the partial-wake receiver.
 * Assumes the transmitter model and the bound checker are compiled with it.
 */
`timescale 1ns/100ps
module uart_rx_partial_wake_tb
    import uart_wake_pkg::*;
();
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic line, wake, stp, st_p, sp_p, eoc, ssec, clr, rdy, valid, en, pw;
    logic pef, fef, ovf, err_irq, end_irq, par_en;
    logic [DATA_BITS-1:0] rx_data;
    // Bit time shortened to keep the run short; wake setting differs from normal
    logic [15:0] ps_n = 16'h0001, cd_n = 16'h3e00, ps_w = 16'h0000, cd_w = 16'h1e00;
    int fails = 0;
    int samples_checked = 0;
    int n_end, n_err;
    logic [31:0] seed = 32'h52b5f865;
    logic [7:0] q[$];

    always #4 clk_in = ~clk_in;
    always @(posedge clk_in)
    begin
        n_end <= n_end + int'(end_irq === 1'b1);
        n_err <= n_err + int'(err_irq === 1'b1);
    end

    uart_wake_tx_model #(.BIT_CLKS(16)) tx_u (.clk_in(clk_in), .line_out(line));
    uart_rx_partial_wake dut_u (.clk_in(clk_in), .rst_in(rst_in),
        .serial_receive_pin_in(line), .standby_wake_enable_in(wake), .cpu_stop_in(stp),
        .channel_start_bit_in(st_p), .channel_stop_bit_in(sp_p),
        .error_irq_enable_in(eoc), .partial_wake_error_stop_in(ssec),
        .parity_enable_in(par_en), .parity_odd_in(par_en), .prescaler_select_in(ps_n),
        .channel_data_in(cd_n), .wake_prescaler_in(ps_w), .wake_channel_data_in(cd_w),
        .clear_errors_in(clr), .rx_data_out(rx_data), .rx_valid_out(valid),
        .rx_ready_in(rdy), .channel_enabled_status_out(en), .partial_wake_mode_out(pw),
        .parity_error_flag_out(pef), .framing_error_flag_out(fef),
        .overrun_error_flag_out(ovf), .receive_error_irq_out(err_irq),
        .transfer_end_irq_out(end_irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_err(input logic e, input logic s);
        return {7'h00, e && !s};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        if (fails == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        tick(1);
        s = 1'b0;
        tick(1);
    endtask
    // bad[0] breaks the stop bit, bad[1] the parity bit
    task automatic frame(input logic [1:0] bad);
        seed = lfsr(seed);
        n_end = 0;
        n_err = 0;
        tx_u.send(seed[7:0], bad[0], {par_en, bad[1]});
        tick(8);
        if (bad == 2'b00)
            q.push_back(seed[7:0]);
    endtask
    task automatic drain(input int n);
        int w;
        for (int i = 0; i < n; i++)
        begin
            w = 0;
            while (valid !== 1'b1 && w < 300)
            begin
                tick(1);
                w++;
            end
            if (w == 300)
            begin
                fails++;
                summarize();
            end
            chk(rx_data, q.pop_front());
            pulse(rdy);
        end
    endtask

    initial
    begin
        {wake, stp, st_p, sp_p, eoc, ssec, clr, rdy} = 8'h00;
        par_en = 1'b0;
        n_end = 0;
        n_err = 0;
        tick(2);
        rst_in = 1'b0;
        pulse(sp_p);
        pulse(clr);
        wake = 1'b1;
        stp = 1'b1;
        pulse(st_p);
        tick(2);
        chk(8'(en), 8'h01);
        chk(8'(pw), 8'h00);
        tx_u.glitch();
        tick(40);
        chk(8'(pw), 8'h01);
        chk(8'(n_end), 8'h00);
        frame(2'b01);
        pulse(rdy);
        pulse(clr);
        for (int c = 0; c < 4; c++)
        begin
            {eoc, ssec} = 2'(c);
            frame(2'b00);
            chk(8'(n_end), 8'h01);
            chk(8'(n_err), 8'h00);
            drain(1);
            frame(2'b01);
            chk(8'(n_end), 8'h01);
            chk(8'(n_err), exp_err(eoc, ssec));
            chk(8'(fef), 8'(!ssec));
            pulse(rdy);
            pulse(clr);
            chk(8'(fef), 8'h00);
        end
        {eoc, ssec} = 2'b10;
        par_en = 1'b1;
        frame(2'b00);
        chk(8'(pef), 8'h00);
        drain(1);
        frame(2'b10);
        chk(8'(pef), 8'h01);
        chk(8'(n_err), 8'h01);
        pulse(rdy);
        pulse(clr);
        chk(8'(pef), 8'h00);
        par_en = 1'b0;
        for (int i = 0; i <= FIFO_DEPTH; i++)
            frame(2'b00);
        void'(q.pop_back());
        chk(8'(n_err), 8'h01);
        chk(8'(ovf), 8'h01);
        drain(FIFO_DEPTH);
        chk(8'(valid), 8'h00);
        pulse(clr);
        pulse(sp_p);
        wake = 1'b0;
        stp = 1'b0;
        tick(4);
        chk(8'(en), 8'h00);
        chk(8'(pw), 8'h00);
        summarize();
    end
endmodule // uart_rx_partial_wake_tb

// ===== verification/uart_wake_tx_model.sv
/*
 * Remote serial transmitter driving the receive pin.
 * Assumes each task is entered just after a rising clock edge.
 */
`timescale 1ns/100ps
module uart_wake_tx_model #(
    parameter int BIT_CLKS = 16
) (
    // Clock
    input wire logic clk_in,
    // Serial line, idle high
    output logic line_out
);
    initial line_out = 1'b1;

    task automatic put(input logic b);
        line_out = b;
        repeat (BIT_CLKS) @(posedge clk_in);
        #1;
    endtask

    // Start, eight data bits LSB first, odd parity bit when par[1] (inverted by par[0]),
    // stop held low when bad_stop
    task automatic send(input logic [7:0] d, input logic bad_stop, input logic [1:0] par);
        put(1'b0);
        for (int i = 0; i < 8; i++)
            put(d[i]);
        if (par[1])
            put(~^d ^ par[0]);
        put(!bad_stop);
        line_out = 1'b1;
    endtask

    // Low pulse far shorter than a start bit
    task automatic glitch();
        line_out = 1'b0;
        repeat (2) @(posedge clk_in);
        #1;
        line_out = 1'b1;
    endtask
endmodule // uart_wake_tx_model
